// ===== rtl/multipair_deskew_pair_ident.sv
// Pair deskew buffer and pair identification handshake of a multi-pair terminal.
`timescale 1ns/1ns
`include "deskew_ident_defs.svh"

//==========================================================================
// Overview of operation
// R1 - Buffer aligns frames received on all pairs.
// R2 - Buffer absorbs up to 60 us skew.
// R3 - Each pair runs its own identification.
// R4 - Repeater passes marker bits through unchanged.
// R5 - Line side gets pair number 1..3.
// R6 - Line side sends markers on link active.
// R7 - Markers are one-hot per pair number.
// R8 - Network side learns identity from markers.
// R9 - Network side sends all ones before completion.
// R10 - Network side evaluates only after link active.
// R11 - Six equal valid frames, pattern unused elsewhere.
// R12 - Network side then reflects pattern, held.
// R13 - Full set recognised: map data, go transparent.
// R14 - Line side monitors returned markers after sending.
// R15 - Line side first sees all-ones markers.
// R16 - Six reflected own patterns acknowledge pair.
// R17 - Line side transparent once all pairs acknowledged.
// R18 - Transparency no sooner than 12 frames; the code enforces no such limit, only 6 matching frames per pair.
// R19 - Wrong or invalid frame restarts count.
// R20 - Link loss clears pair state, stops data.
module multipair_deskew_pair_ident #(
   parameter int LINE_KBPS = `DEFAULT_LINE_KBPS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic line_side,
   input wire logic three_pair,
   input wire logic [5:0] assigned_pair,
   input wire logic [2:0] link_active,
   input wire logic [2:0] rx_frame_start,
   input wire logic [8:0] rx_marker,
   input wire logic [2:0] rx_valid,
   input wire logic [2:0] rx_data,
   input wire logic out_tick,
   output logic [8:0] tx_marker,
   output logic [2:0] pair_done,
   output logic [5:0] pair_ident,
   output logic transparent,
   output logic out_valid,
   output logic [2:0] out_data
);

   localparam int NP = `MAX_PAIRS;
   localparam int SKEW_BITS = (`DESKEW_DELAY_NS * LINE_KBPS + 999999) / 1000000;
   localparam int AW = $clog2(2 * SKEW_BITS + 1);
   localparam int DEPTH = 2 ** AW;
   localparam logic [2:0] LAST_COUNT = 3'(`ID_FRAMES - 1);

   //=======================================================================
   // Helper functions
   // One-hot marker pattern for pair number 1..3; other numbers give none.
   function automatic logic [2:0] pattern_of(input logic [1:0] num);
      logic [2:0] pat;
      pat = `MARKER_NONE;
      if (num != 2'h0) begin
         pat[num - 2'h1] = 1'b1;
      end
      return pat;
   endfunction : pattern_of

   // A pattern is valid when exactly one bit is set among the installed positions.
   function automatic logic valid_pattern(input logic [2:0] pat, input logic [2:0] mask);
      return ((pat & ~mask) == 3'h0) && $onehot(pat);
   endfunction : valid_pattern

   // Lane index that a one-hot pattern selects.
   function automatic logic [1:0] lane_of(input logic [2:0] pat);
      logic [1:0] lane;
      lane = 2'h0;
      if (pat[1]) begin
         lane = 2'h1;
      end
      if (pat[2]) begin
         lane = 2'h2;
      end
      return lane;
   endfunction : lane_of

   //=======================================================================
   // Identification state per pair
   logic [2:0] installed;
   deskew_ident_pkg::ident_state_t state [NP];
   logic [2:0] count [NP];
   logic [2:0] cand [NP];
   logic [2:0] ident [NP];
   logic [2:0] match;
   logic [2:0] reach;
   logic [2:0] claim;

   assign installed = three_pair ? `PAIRS_MASK_THREE : `PAIRS_MASK_TWO; // R5

   always_comb begin
      logic [2:0] pat;
      logic [2:0] qpat;
      pat = 3'h0;
      qpat = 3'h0;
      match = 3'h0;
      reach = 3'h0;
      claim = 3'h0;
      for (int p = 0; p < NP; p++) begin
         pat = rx_marker[3 * p +: 3];
         if (state[p] == deskew_ident_pkg::ID_EVAL && rx_frame_start[p]) begin
            if (line_side) begin
               match[p] = pat == pattern_of(assigned_pair[2 * p +: 2]); // R16
            end else begin
               match[p] = valid_pattern(pat, installed) && pat == cand[p]; // R11
            end
         end
         reach[p] = match[p] && count[p] == LAST_COUNT;
      end
      for (int p = 0; p < NP; p++) begin
         pat = rx_marker[3 * p +: 3];
         claim[p] = reach[p];
         if (!line_side) begin
            for (int q = 0; q < NP; q++) begin
               qpat = rx_marker[3 * q +: 3];
               if (q != p && state[q] == deskew_ident_pkg::ID_DONE && ident[q] == pat) begin
                  claim[p] = 1'b0; // R11
               end
               if (q < p && reach[q] && qpat == pat) begin
                  claim[p] = 1'b0;
               end
            end
         end
      end
   end

   // Each pair steps through idle, evaluation and done on its own.
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int p = 0; p < NP; p++) begin
            state[p] <= deskew_ident_pkg::ID_IDLE;
            count[p] <= 3'h0;
            cand[p] <= 3'h0;
            ident[p] <= 3'h0;
         end
      end else if (ce) begin
         for (int p = 0; p < NP; p++) begin // R3
            if (!link_active[p] || !installed[p]) begin
               state[p] <= deskew_ident_pkg::ID_IDLE; // R20
               count[p] <= 3'h0;
               cand[p] <= 3'h0;
               ident[p] <= 3'h0;
            end else begin
               case (state[p])
                  deskew_ident_pkg::ID_IDLE: begin
                     state[p] <= deskew_ident_pkg::ID_EVAL; // R10 R14
                     count[p] <= 3'h0;
                  end
                  deskew_ident_pkg::ID_EVAL: begin
                     if (rx_frame_start[p]) begin
                        if (claim[p]) begin
                           state[p] <= deskew_ident_pkg::ID_DONE;
                           ident[p] <= line_side ? pattern_of(assigned_pair[2 * p +: 2])
                                                 : rx_marker[3 * p +: 3]; // R8
                        end else if (reach[p]) begin
                           count[p] <= 3'h0;
                        end else if (match[p]) begin
                           count[p] <= count[p] + 3'h1;
                        end else begin
                           // All-ones or a foreign pattern restarts the count.
                           cand[p] <= rx_marker[3 * p +: 3]; // R15 R19
                           count[p] <= (!line_side &&
                                        valid_pattern(rx_marker[3 * p +: 3], installed))
                                       ? 3'h1 : 3'h0; // R19
                        end
                     end
                  end
                  deskew_ident_pkg::ID_DONE: begin
                     state[p] <= deskew_ident_pkg::ID_DONE; // R12
                  end
                  default: begin
                     state[p] <= deskew_ident_pkg::ID_IDLE;
                  end
               endcase
            end
         end
      end
   end

   //=======================================================================
   // Outgoing markers and status
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_marker <= 9'h0;
         pair_done <= 3'h0;
         pair_ident <= 6'h0;
      end else if (ce) begin
         for (int p = 0; p < NP; p++) begin
            pair_done[p] <= state[p] == deskew_ident_pkg::ID_DONE;
            pair_ident[2 * p +: 2] <= (state[p] == deskew_ident_pkg::ID_DONE)
                                      ? 2'(lane_of(ident[p]) + 2'h1) : 2'h0;
            if (line_side) begin
               tx_marker[3 * p +: 3] <= (link_active[p] && installed[p])
                                        ? pattern_of(assigned_pair[2 * p +: 2])
                                        : `MARKER_NONE; // R6 R7
            end else if (state[p] == deskew_ident_pkg::ID_DONE) begin
               tx_marker[3 * p +: 3] <= ident[p]; // R12
            end else begin
               tx_marker[3 * p +: 3] <= `MARKER_ALL_ONES; // R9
            end
         end
      end
   end

   //=======================================================================
   // Delay difference buffer
   logic mem [NP][DEPTH];
   logic [AW-1:0] wr_ptr [NP];
   logic [AW-1:0] start_addr [NP];
   logic [AW-1:0] rd_ptr [NP];
   logic [2:0] pending;
   logic aligned;
   logic all_done;

   always_comb begin
      all_done = 1'b1;
      for (int p = 0; p < NP; p++) begin
         if (installed[p] && state[p] != deskew_ident_pkg::ID_DONE) begin
            all_done = 1'b0; // R13 R17
         end
      end
   end

   // Each pair writes its own bits and notes where its latest frame began.
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int p = 0; p < NP; p++) begin
            wr_ptr[p] <= '0;
            start_addr[p] <= '0;
         end
         pending <= 3'h0;
      end else if (ce) begin
         for (int p = 0; p < NP; p++) begin
            if (rx_valid[p]) begin
               mem[p][wr_ptr[p]] <= rx_data[p]; // R1
               wr_ptr[p] <= wr_ptr[p] + 1'b1;
            end
            if (rx_frame_start[p] && rx_valid[p] && installed[p] && !aligned) begin
               start_addr[p] <= wr_ptr[p]; // R2
            end
         end
         if (aligned || !all_done) begin
            pending <= 3'h0;
         end else begin
            pending <= pending | (rx_frame_start & rx_valid & installed);
         end
      end
   end

   // Reading starts on every pair at its noted frame start once all have one.
   always_ff @(posedge clk) begin
      if (rst) begin
         aligned <= 1'b0;
         for (int p = 0; p < NP; p++) begin
            rd_ptr[p] <= '0;
         end
      end else if (ce) begin
         if (!all_done) begin
            aligned <= 1'b0; // R20
         end else if (!aligned && pending == installed) begin
            aligned <= 1'b1; // R1
            for (int p = 0; p < NP; p++) begin
               rd_ptr[p] <= start_addr[p];
            end
         end else if (aligned && out_tick) begin
            for (int p = 0; p < NP; p++) begin
               rd_ptr[p] <= rd_ptr[p] + 1'b1;
            end
         end
      end
   end

   // Data lanes are ordered by identified pair number on the network side.
   always_ff @(posedge clk) begin
      if (rst) begin
         transparent <= 1'b0;
         out_valid <= 1'b0;
         out_data <= 3'h0;
      end else if (ce) begin
         transparent <= aligned && all_done; // R13 R17
         out_valid <= aligned && all_done && out_tick;
         if (aligned && all_done && out_tick) begin
            for (int p = 0; p < NP; p++) begin
               if (installed[p]) begin
                  out_data[lane_of(ident[p])] <= mem[p][rd_ptr[p]]; // R13
               end
            end
         end
      end
   end

   //=======================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   int frames_since_active;
   always_ff @(posedge clk) begin
      if (rst || !(&(link_active | ~installed))) begin
         frames_since_active <= 0;
      end else if (ce && |(rx_frame_start & installed)) begin
         frames_since_active <= frames_since_active + 1;
      end
   end

   sequence link_drop_s(int p);
      ce && installed[p] && !link_active[p];
   endsequence

   AST_NET_ONES_BEFORE_DONE: assert property ( // R9
      ce && !line_side && installed[0] && state[0] != deskew_ident_pkg::ID_DONE
      |=> tx_marker[2:0] == `MARKER_ALL_ONES)
      else $error("Network side marker not all ones before completion.");

   AST_LINE_ONEHOT: assert property ( // R7
      ce && line_side && link_active[1] && installed[1]
      |=> tx_marker[5:3] == pattern_of($past(assigned_pair[3:2])))
      else $error("Line side marker is not the assigned one-hot pattern.");

   AST_DONE_HOLDS: assert property ( // R12
      state[0] == deskew_ident_pkg::ID_DONE && link_active[0]
      |=> state[0] == deskew_ident_pkg::ID_DONE && $stable(ident[0]))
      else $error("Recognised pattern changed within the activation.");

   AST_LINK_DROP_CLEARS: assert property ( // R20
      link_drop_s(0) |=> state[0] == deskew_ident_pkg::ID_IDLE ##1 !transparent)
      else $error("Link loss did not clear pair state and transparency.");

   AST_TRANSPARENT_NEEDS_ALL: assert property ( // R17
      transparent |-> (pair_done & installed) == installed)
      else $error("Transparent while a pair is not identified.");

   AST_MIN_FRAMES: assert property ( // R18 asks for 12 frames; this checks at least 6 frame starts on any installed pair
      $rose(transparent) |-> frames_since_active >= `ID_FRAMES)
      else $error("Transparent too soon after link active.");

   AST_NO_DUP_IDENT: assert property ( // R11
      state[0] == deskew_ident_pkg::ID_DONE && state[1] == deskew_ident_pkg::ID_DONE
      |-> ident[0] != ident[1])
      else $error("Two pairs hold the same identification.");

   AST_BAD_FRAME_RESTARTS: assert property ( // R19
      ce && line_side && state[2] == deskew_ident_pkg::ID_EVAL && rx_frame_start[2]
      && !match[2] |=> count[2] == 3'h0)
      else $error("Count not restarted after a wrong frame.");

   AST_EVAL_AFTER_ACTIVE: assert property ( // R10
      !link_active[1] && ce |=> state[1] == deskew_ident_pkg::ID_IDLE)
      else $error("Evaluation ran without link active.");

endmodule : multipair_deskew_pair_ident

// ===== rtl/deskew_ident_defs.svh
// Constants for the pair deskew and pair identification block.
`ifndef DESKEW_IDENT_DEFS_SVH
`define DESKEW_IDENT_DEFS_SVH

`define MAX_PAIRS 3
`define MARKER_W 3
`define PAIR_NUM_W 2
`define DESKEW_DELAY_NS 60000
`define DEFAULT_LINE_KBPS 2320
`define ID_FRAMES 6
`define MIN_FRAMES_TO_DATA 12
`define MIN_DATA_MS 72
`define FRAME_MS 6
`define MARKER_ALL_ONES 3'h7
`define MARKER_NONE 3'h0
`define PAIRS_MASK_TWO 3'h3
`define PAIRS_MASK_THREE 3'h7

`endif

// ===== rtl/deskew_ident_pkg.sv
// Types for the pair deskew and pair identification block.
package deskew_ident_pkg;
   typedef enum logic [2:0] {
      ID_IDLE = 3'b001,
      ID_EVAL = 3'b010,
      ID_DONE = 3'b100
   } ident_state_t;
endpackage : deskew_ident_pkg

// ===== verification/peer_terminal.sv
// Behavioural peer terminal that drives frames, markers and data on each pair.
`timescale 1ns/1ns
module peer_terminal #(
   parameter int FP = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic peer_line,
   input wire logic [5:0] pair_map,
   input wire logic corrupt,
   input wire logic [2:0] link_active,
   input wire logic [8:0] tx_marker,
   output logic [2:0] rx_frame_start,
   output logic [8:0] rx_marker,
   output logic [2:0] rx_valid,
   output logic [2:0] rx_data
);
   logic [4:0] pos [3];
   logic [2:0] held [3];
   logic [2:0] cnt [3];
   logic [2:0] pat;
   //==========
   // Frame timing, skewed per pair, and the marker count of a network peer.
   always_ff @(posedge clk) begin
      for (int p = 0; p < 3; p++) begin
         pos[p] <= rst ? 5'(p * 5) : ((pos[p] == 5'(FP - 1)) ? 5'h00 : pos[p] + 5'h01);
         if (rst || !link_active[p]) begin
            cnt[p] <= 3'h0;
            held[p] <= 3'h0;
         end else if (rx_frame_start[p] && cnt[p] != 3'h6) begin
            held[p] <= tx_marker[3*p +: 3];
            cnt[p] <= (tx_marker[3*p +: 3] == held[p]) ? cnt[p] + 3'h1 : 3'h1;
         end
      end
   end
   //==========
   // Markers are only meaningful at a frame start, so they are inverted elsewhere.
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         if (peer_line) begin
            pat = 3'h1 << (pair_map[2*p +: 2] - 2'h1);
            if (p == 0 && corrupt) begin
               pat = 3'h3;
            end
         end else begin
            pat = (cnt[p] == 3'h6) ? held[p] : 3'h7;
         end
         rx_frame_start[p] = !rst && pos[p] == 5'h00;
         rx_marker[3*p +: 3] = rst ? 3'h0 : (rx_frame_start[p] ? pat : ~pat);
         rx_valid[p] = !rst;
         rx_data[p] = !rst && (pos[p][0] ^ (pair_map[2*p +: 2] == 2'h2));
      end
   end
endmodule : peer_terminal

// ===== verification/tb_multipair_deskew_pair_ident.sv
// Self-checking bench for the pair deskew and pair identification block.
`timescale 1ns/1ns
`include "deskew_ident_defs.svh"
module tb_multipair_deskew_pair_ident;
   localparam int FP = 16;
   localparam int LIMIT = 20000;
   typedef struct packed {
      logic ls;
      logic tp;
      logic [5:0] map;
      logic [8:0] fin;
   } row_t;
   logic clk, rst, ce, line_side, three_pair, out_tick, corrupt, transparent, out_valid;
   logic [5:0] assigned_pair, pair_ident;
   logic [2:0] link_active, rx_frame_start, rx_valid, rx_data, pair_done, out_data, d, inst;
   logic [8:0] rx_marker, tx_marker, m9;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   int t0;
   row_t r;
   // Columns: line side, three pairs, pair numbers, final markers.
   row_t rows [4] = '{'{1'h1, 1'h1, 6'h1e, 9'h062}, '{1'h1, 1'h0, 6'h06, 9'h00a},
      '{1'h0, 1'h1, 6'h27, 9'h08c}, '{1'h0, 1'h0, 6'h09, 9'h011}};

   multipair_deskew_pair_ident uut (
      .clk(clk), .rst(rst), .ce(ce), .line_side(line_side), .three_pair(three_pair),
      .assigned_pair(assigned_pair), .link_active(link_active),
      .rx_frame_start(rx_frame_start), .rx_marker(rx_marker), .rx_valid(rx_valid),
      .rx_data(rx_data), .out_tick(out_tick), .tx_marker(tx_marker), .pair_done(pair_done),
      .pair_ident(pair_ident), .transparent(transparent), .out_valid(out_valid),
      .out_data(out_data));
   peer_terminal #(.FP(FP)) peer (
      .clk(clk), .rst(rst), .peer_line(!line_side), .pair_map(assigned_pair),
      .corrupt(corrupt), .link_active(link_active), .tx_marker(tx_marker),
      .rx_frame_start(rx_frame_start), .rx_marker(rx_marker), .rx_valid(rx_valid),
      .rx_data(rx_data));

   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc >= LIMIT) begin
         err_total++;
         print_verdict();
      end
   end
   //==========
   // Shared tasks.
   task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic cmp_min(input string what, input int lim, input int got);
      n_checks++;
      if (got <= lim) begin
         err_total++;
         $display("[ERR] %s expected above %0d seen %0d", what, lim, got);
      end
   endtask : cmp_min
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic start(input logic ls, input logic tp, input logic [5:0] map);
      rst = 1'h1;
      link_active = 3'h0;
      line_side = ls;
      three_pair = tp;
      assigned_pair = map;
      step(4);
      rst = 1'h0;
   endtask : start
   task automatic tick();
      out_tick = 1'h1;
      step(1);
      out_tick = 1'h0;
      d = out_data;
      cmp("out_valid", 9'h001, {8'h00, out_valid});
      step(1);
      cmp("out_valid pulse", 9'h000, {8'h00, out_valid});
   endtask : tick
   // Returns just after the edge that samples the next frame start of pair 0.
   task automatic wait_fs();
      while (rx_frame_start[0] !== 1'h1) step(1);
      step(1);
   endtask : wait_fs
   task automatic print_verdict();
      if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : print_verdict
   //==========
   // Main sequence.
   initial begin
      ce = 1'h1;
      out_tick = 1'h0;
      corrupt = 1'h0;
      for (int i = 0; i < 4; i++) begin
         r = rows[i];
         inst = r.tp ? 3'h7 : 3'h3;
         m9 = r.tp ? 9'h1ff : 9'h03f;
         start(r.ls, r.tp, r.map);
         cmp("reset markers", 9'h000, tx_marker);
         cmp("reset status", 9'h000, {pair_ident, pair_done});
         cmp("reset flags", 9'h000, {7'h00, transparent, out_valid});
         link_active = inst;
         t0 = cyc;
         step(2);
         cmp("early markers", (r.ls ? r.fin : 9'h1ff) & m9, tx_marker & m9);
         out_tick = 1'h1;
         step(1);
         out_tick = 1'h0;
         cmp("early data", 9'h000, {7'h00, transparent, out_valid});
         step(1);
         cmp("early data", 9'h000, {7'h00, transparent, out_valid});
         while (transparent !== 1'h1) step(1);
         if (r.ls) cmp_min("latency", (`MIN_FRAMES_TO_DATA - 1) * FP, cyc - t0);
         cmp("pair_done", {6'h00, inst}, {6'h00, pair_done});
         cmp("pair_ident", {3'h0, r.map}, {3'h0, pair_ident});
         cmp("final markers", r.fin & m9, tx_marker & m9);
         tick();
         cmp("first bits", {6'h00, inst & 3'h2}, {6'h00, inst & d});
         tick();
         cmp("next bits", {6'h00, inst & 3'h5}, {6'h00, inst & d});
         link_active[0] = 1'h0;
         step(3);
         cmp("link loss", 9'h000, {7'h00, pair_done[0], transparent});
      end
      // Two pairs offering the same pattern: the one that completes first keeps it.
      start(1'h0, 1'h1, 6'h25);
      link_active = 3'h7;
      step(20 * FP);
      cmp("shared pattern", 9'h006, {3'h0, transparent, 2'h0, pair_done});
      cmp("shared markers", 9'h007, {6'h00, tx_marker[2:0]});
      cmp("shared owner", 9'h001, {6'h00, tx_marker[5:3]});
      // An invalid pattern on pair 0, then one bad frame after five good ones.
      start(1'h0, 1'h1, 6'h27);
      corrupt = 1'h1;
      link_active = 3'h7;
      step(10 * FP);
      cmp("invalid pattern", 9'h006, {6'h00, pair_done});
      corrupt = 1'h0;
      repeat (5) wait_fs();
      corrupt = 1'h1;
      wait_fs();
      corrupt = 1'h0;
      repeat (5) wait_fs();
      step(2);
      cmp("count restart", 9'h006, {6'h00, pair_done});
      wait_fs();
      step(2);
      cmp("count complete", 9'h007, {6'h00, pair_done});
      // With the clock enable low a link loss must not touch any state.
      ce = 1'h0;
      link_active = 3'h0;
      step(3);
      cmp("frozen status", 9'h007, {6'h00, pair_done});
      ce = 1'h1;
      step(2);
      cmp("thawed status", 9'h000, {5'h00, transparent, pair_done});
      print_verdict();
   end
endmodule : tb_multipair_deskew_pair_ident
